// ===== rtl/tdc_pkg.sv
// package: register map, field layout and decoded config of the tdr setup block
package tdc_pkg;

  // ****************************************
  // register map
  // ****************************************
  localparam logic [15:0] TDC_OFS_CONTROL = 16'h0170;
  localparam logic [15:0] TDC_OFS_RSVD_A = 16'h0171;
  localparam logic [15:0] TDC_OFS_RSVD_B = 16'h0172;
  localparam logic [15:0] TDC_OFS_TIMING = 16'h0173;

  // ****************************************
  // control register fields
  // ****************************************
  localparam int TDC_CROSS_DIS_BIT = 14;
  localparam int TDC_CHAN_SEL_BIT = 13;
  localparam int TDC_DC_HOLD_BIT = 12;
  localparam int TDC_AVG_LSB = 8;
  localparam int TDC_SEG_LSB = 4;
  localparam logic [15:0] TDC_CONTROL_WMASK = 16'h7770;
  localparam logic [15:0] TDC_CONTROL_RESET = 16'h0410;

  // ****************************************
  // timing register fields
  // ****************************************
  localparam int TDC_DUR_LSB = 8;
  localparam int TDC_SKIP_LSB = 0;
  localparam logic [15:0] TDC_TIMING_RESET = 16'h1304;

  // ****************************************
  // code ranges
  // ****************************************
  localparam logic [2:0] TDC_AVG_RSVD = 3'h7;
  localparam logic [2:0] TDC_SEG_FIRST = 3'h1;
  localparam logic [2:0] TDC_SEG_LAST = 3'h5;
  localparam logic [6:0] TDC_AVG_ONE = 7'h01;

  // decoded settings handed to the tdr engine
  typedef struct packed {
    logic tx_chan_b;
    logic rx_chan_b;
    logic hold_dc_removal_state;
    logic [2:0] avg_code;
    logic [6:0] avg_cycles;
    logic avg_valid;
    logic [2:0] seg_code;
    logic seg_valid;
    logic [7:0] seg_duration;
    logic [7:0] initial_skip;
  } tdc_cfg_t;

endpackage

// ===== rtl/tdc_top.sv
// tdr cable diagnostic setup registers and decoded engine configuration
`timescale 1ns/10ps
`default_nettype none

module tdc_top #(
  parameter int ADDR_W = 16
) (
  input wire logic CLK_SYS,
  input wire logic ARST_N,
  input wire logic [ADDR_W-1:0] REG_ADDR,
  input wire logic REG_WR,
  input wire logic [15:0] REG_WDATA,
  input wire logic REG_RD,
  output logic [15:0] REG_RDATA,
  output logic REG_RVALID,
  input wire logic TDR_START,
  output logic DC_REM_INIT,
  output tdc_pkg::tdc_cfg_t CFG
);
  import tdc_pkg::*;

  generate
    if (ADDR_W < 9) begin : g_bad_addr_w
      $error("ADDR_W too small for the register map");
    end
  endgenerate

  // ****************************************
  // register file
  // ****************************************
  logic [15:0] ctrl_q;
  logic [15:0] ctrl_d;
  logic [15:0] timing_q;
  logic [15:0] timing_d;
  logic [15:0] rdata_q;
  logic [15:0] rdata_d;
  logic rvalid_q;
  logic [15:0] addr16;

  assign addr16 = 16'(REG_ADDR);

  always_comb begin
    ctrl_d = ctrl_q;
    timing_d = timing_q;
    rdata_d = rdata_q;
    if (REG_WR && addr16 == TDC_OFS_CONTROL) begin
      ctrl_d = REG_WDATA & TDC_CONTROL_WMASK;
    end
    if (REG_WR && addr16 == TDC_OFS_TIMING) begin
      timing_d = REG_WDATA;
    end
    if (REG_RD) begin
      case (addr16)
        TDC_OFS_CONTROL: rdata_d = ctrl_q;
        TDC_OFS_TIMING: rdata_d = timing_q;
        default: rdata_d = 16'h0000;
      endcase
    end
  end

  always_ff @(posedge CLK_SYS or negedge ARST_N) begin
    if (!ARST_N) begin
      ctrl_q <= TDC_CONTROL_RESET;
      timing_q <= TDC_TIMING_RESET;
      rdata_q <= 16'h0000;
      rvalid_q <= 1'b0;
    end else begin
      ctrl_q <= ctrl_d;
      timing_q <= timing_d;
      rdata_q <= rdata_d;
      rvalid_q <= REG_RD;
    end
  end

  assign REG_RDATA = rdata_q;
  assign REG_RVALID = rvalid_q;

  // ****************************************
  // decoded configuration
  // ****************************************
  tdc_cfg_t cfg_q;
  tdc_cfg_t cfg_d;
  logic dc_init_q;
  logic dc_init_d;

  always_comb begin
    cfg_d.tx_chan_b = ctrl_d[TDC_CHAN_SEL_BIT];
    // listen on the partner channel unless cross listening is disabled
    cfg_d.rx_chan_b = ctrl_d[TDC_CROSS_DIS_BIT] ? ctrl_d[TDC_CHAN_SEL_BIT]
                      : ~ctrl_d[TDC_CHAN_SEL_BIT];
    cfg_d.hold_dc_removal_state = ctrl_d[TDC_DC_HOLD_BIT];
    cfg_d.avg_code = ctrl_d[TDC_AVG_LSB +: 3];
    cfg_d.avg_valid = (cfg_d.avg_code != TDC_AVG_RSVD);
    cfg_d.avg_cycles = cfg_d.avg_valid
                       ? 7'(TDC_AVG_ONE << cfg_d.avg_code) : 7'h00;
    cfg_d.seg_code = ctrl_d[TDC_SEG_LSB +: 3];
    cfg_d.seg_valid = (cfg_d.seg_code >= TDC_SEG_FIRST)
                      && (cfg_d.seg_code <= TDC_SEG_LAST);
    cfg_d.seg_duration = timing_d[TDC_DUR_LSB +: 8];
    cfg_d.initial_skip = timing_d[TDC_SKIP_LSB +: 8];
    // dc removal restarts with each run unless software holds it
    dc_init_d = TDR_START && !ctrl_q[TDC_DC_HOLD_BIT];
  end

  always_ff @(posedge CLK_SYS or negedge ARST_N) begin
    if (!ARST_N) begin
      cfg_q <= '0;
      cfg_q.rx_chan_b <= 1'b1;
      cfg_q.avg_code <= TDC_CONTROL_RESET[TDC_AVG_LSB +: 3];
      cfg_q.avg_cycles <=
        7'(TDC_AVG_ONE << TDC_CONTROL_RESET[TDC_AVG_LSB +: 3]);
      cfg_q.avg_valid <= 1'b1;
      cfg_q.seg_code <= TDC_CONTROL_RESET[TDC_SEG_LSB +: 3];
      cfg_q.seg_valid <= 1'b1;
      cfg_q.seg_duration <= TDC_TIMING_RESET[TDC_DUR_LSB +: 8];
      cfg_q.initial_skip <= TDC_TIMING_RESET[TDC_SKIP_LSB +: 8];
      dc_init_q <= 1'b0;
    end else begin
      cfg_q <= cfg_d;
      dc_init_q <= dc_init_d;
    end
  end

  assign CFG = cfg_q;
  assign DC_REM_INIT = dc_init_q;

  // ****************************************
  // checks
  // ****************************************
  logic out_of_reset_q;

  always_ff @(posedge CLK_SYS or negedge ARST_N) begin
    if (!ARST_N) begin
      out_of_reset_q <= 1'b0;
    end else begin
      out_of_reset_q <= 1'b1;
    end
  end

  a_rx_chan_pick: assert property (
    @(posedge CLK_SYS) disable iff (!ARST_N)
    out_of_reset_q |-> CFG.rx_chan_b == (ctrl_q[14] ? ctrl_q[13] : ~ctrl_q[13]))
    else $error("listen channel does not follow cross control");

  a_tx_chan_write: assert property (
    @(posedge CLK_SYS) disable iff (!ARST_N)
    (REG_WR && addr16 == TDC_OFS_CONTROL)
    |=> CFG.tx_chan_b == $past(REG_WDATA[13]))
    else $error("transmit channel not taken from write");

  a_dc_hold_run: assert property (
    @(posedge CLK_SYS) disable iff (!ARST_N)
    TDR_START |=> DC_REM_INIT == !$past(ctrl_q[12]))
    else $error("dc removal init wrong for hold setting");

  a_avg_count: assert property (
    @(posedge CLK_SYS) disable iff (!ARST_N)
    CFG.avg_valid |-> CFG.avg_cycles == 7'(7'h01 << CFG.avg_code)
    and CFG.avg_valid == (CFG.avg_code != 3'h7))
    else $error("average count mismatch");

  a_seg_range: assert property (
    @(posedge CLK_SYS) disable iff (!ARST_N)
    CFG.seg_valid == (CFG.seg_code inside {3'h1, 3'h2, 3'h3, 3'h4, 3'h5})
    and CFG.seg_code == ctrl_q[6:4])
    else $error("segment decode mismatch");

  a_duration_write: assert property (
    @(posedge CLK_SYS) disable iff (!ARST_N)
    (REG_WR && addr16 == TDC_OFS_TIMING)
    |=> CFG.seg_duration == $past(REG_WDATA[15:8]))
    else $error("duration not taken from write");

  a_skip_write: assert property (
    @(posedge CLK_SYS) disable iff (!ARST_N)
    (REG_WR && addr16 == TDC_OFS_TIMING) ##1 !REG_WR [*2]
    |-> CFG.initial_skip == $past(REG_WDATA[7:0], 2))
    else $error("initial skip not held from write");

  a_reset_value: assert property (
    @(posedge CLK_SYS) disable iff (!ARST_N)
    !out_of_reset_q |-> ctrl_q == 16'h0410 && CFG.avg_cycles == 7'h10)
    else $error("control reset value wrong");

  a_reserved_zero: assert property (
    @(posedge CLK_SYS) disable iff (!ARST_N)
    REG_RD |=> REG_RVALID && (($past(addr16) == 16'h0170)
    ? ((REG_RDATA & 16'h888F) == 16'h0000)
    : (($past(addr16) == 16'h0173) || (REG_RDATA == 16'h0000))))
    else $error("reserved bits read non zero");

  a_avg_reserved: assert property (
    @(posedge CLK_SYS) disable iff (!ARST_N)
    CFG.avg_code == 3'h7 |-> !CFG.avg_valid && CFG.avg_cycles == 7'h00)
    else $error("reserved average code not flagged");

  a_dc_init_quiet: assert property (
    @(posedge CLK_SYS) disable iff (!ARST_N)
    !TDR_START |=> !DC_REM_INIT)
    else $error("dc removal init without run start");

  a_rsvd_write_ignored: assert property (
    @(posedge CLK_SYS) disable iff (!ARST_N)
    (REG_WR && (addr16 == 16'h0171 || addr16 == 16'h0172))
    |=> $stable(ctrl_q) && $stable(timing_q))
    else $error("reserved register write changed settings");

  a_read_answer: assert property (
    @(posedge CLK_SYS) disable iff (!ARST_N)
    REG_RVALID == $past(REG_RD))
    else $error("read answer not one cycle after read");

  a_timing_reset: assert property (
    @(posedge CLK_SYS) disable iff (!ARST_N)
    !out_of_reset_q |-> timing_q == 16'h1304)
    else $error("timing reset value wrong");

endmodule

`default_nettype wire

// ===== verif/tdc_eng_model.sv
// tdr engine stand-in: issues run starts, counts dc removal reinits
`timescale 1ns/10ps
`default_nettype none
module tdc_eng_model (
  input wire logic clk,
  input wire logic dc_init,
  output logic start,
  output int inits
);
  initial begin
    start = 1'b0;
    inits = 0;
  end
  always @(posedge clk) begin
    if (dc_init === 1'b1) inits <= inits + 1;
  end
  task automatic fire();
    @(posedge clk);
    start <= 1'b1;
    @(posedge clk);
    start <= 1'b0;
  endtask
endmodule
`default_nettype wire

// ===== verif/tb_top.sv
// testbench: register access, decoded config and dc reinit
`timescale 1ns/10ps
`default_nettype none
module tb_top;
  import tdc_pkg::*;
  logic clk_sys, arst_n, reg_wr, reg_rd, rvalid, dc_init, start;
  logic [15:0] addr, wdata, rdata, e;
  tdc_cfg_t cfg;
  int error_cnt, n_checks, base, i, inits;
  localparam logic [7:0] DUR [1:5] = '{8'h0D, 8'h0D, 8'h1A, 8'h34, 8'h8F};
  localparam logic [7:0] SKP [1:5] = '{8'h07, 8'h14, 8'h21, 8'h3B, 8'h6F};
  tdc_top tdc_top_i (.CLK_SYS(clk_sys), .ARST_N(arst_n), .REG_ADDR(addr),
    .REG_WR(reg_wr), .REG_WDATA(wdata), .REG_RD(reg_rd), .REG_RDATA(rdata),
    .REG_RVALID(rvalid), .TDR_START(start), .DC_REM_INIT(dc_init),
    .CFG(cfg));
  tdc_eng_model tdc_eng_model_i (.clk(clk_sys), .dc_init(dc_init),
    .start(start), .inits(inits));
  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    n_checks++;
    if (seen !== exp) begin
      error_cnt++;
      $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic stop_test();
    $display("checks %0d errors %0d", n_checks, error_cnt);
    if (error_cnt == 0 && n_checks > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask
  task automatic wr(input logic [15:0] a, input logic [15:0] d);
    @(posedge clk_sys);
    addr <= a;
    wdata <= d;
    reg_wr <= 1'b1;
    @(posedge clk_sys);
    reg_wr <= 1'b0;
  endtask
  task automatic rd(input logic [15:0] a, input logic [15:0] exp);
    int n;
    @(posedge clk_sys);
    addr <= a;
    reg_rd <= 1'b1;
    @(posedge clk_sys);
    reg_rd <= 1'b0;
    n = 0;
    #1;
    while (rvalid !== 1'b1 && n < 4) begin
      @(posedge clk_sys);
      #1;
      n++;
    end
    if (n == 4) begin
      error_cnt++;
      stop_test();
    end else begin
      check(rdata, exp);
    end
  endtask
  initial begin
    clk_sys = 1'b0;
    forever #50 clk_sys = ~clk_sys;
  end
  initial begin
    arst_n = 1'b0;
    reg_wr = 1'b0;
    reg_rd = 1'b0;
    addr = 16'h0000;
    wdata = 16'h0000;
    error_cnt = 0;
    n_checks = 0;
    repeat (10) @(posedge clk_sys);
    arst_n <= 1'b1;
    rd(TDC_OFS_CONTROL, 16'h0410);
    rd(TDC_OFS_TIMING, 16'h1304);
    check({cfg.seg_duration, cfg.initial_skip}, 16'h1304);
    check({cfg.tx_chan_b, cfg.rx_chan_b, cfg.hold_dc_removal_state,
      cfg.avg_valid, cfg.seg_valid, 1'b0, cfg.avg_code, cfg.avg_cycles},
      {5'b01011, 1'b0, 3'h4, 7'h10});
    check({5'h00, cfg.seg_code, 8'h00}, 16'h0100);
    $display("test reset done");
    for (i = 0; i < 8; i++) begin
      e = {1'b0, i[0], i[1], i[0], 1'b0, i[2:0], 1'b0, i[2:0], 4'h0};
      wr(TDC_OFS_CONTROL, e | 16'h888F);
      rd(TDC_OFS_CONTROL, e);
      check({cfg.tx_chan_b, cfg.rx_chan_b, cfg.hold_dc_removal_state,
        cfg.avg_valid, cfg.seg_valid, 4'h0, cfg.avg_cycles},
        {i[1], i[1] ^ ~i[0], i[0], i != 7, i >= 1 && i <= 5, 4'h0,
        i < 7 ? 7'(1 << i) : 7'h00});
      check({5'h00, cfg.avg_code, 5'h00, cfg.seg_code},
        {5'h00, i[2:0], 5'h00, i[2:0]});
    end
    $display("test control done");
    for (i = 1; i < 6; i++) begin
      wr(TDC_OFS_CONTROL, 16'h0400 | 16'(i << 4));
      wr(TDC_OFS_TIMING, {DUR[i], SKP[i]});
      rd(TDC_OFS_TIMING, {DUR[i], SKP[i]});
      check({cfg.seg_duration, cfg.initial_skip}, {DUR[i], SKP[i]});
    end
    $display("test timing done");
    wr(TDC_OFS_RSVD_A, 16'hFFFF);
    wr(TDC_OFS_RSVD_B, 16'hFFFF);
    rd(TDC_OFS_RSVD_A, 16'h0000);
    rd(TDC_OFS_RSVD_B, 16'h0000);
    rd(16'h01FF, 16'h0000);
    rd(TDC_OFS_CONTROL, 16'h0450);
    $display("test reserved done");
    @(posedge clk_sys);
    arst_n <= 1'b0;
    repeat (2) @(posedge clk_sys);
    arst_n <= 1'b1;
    rd(TDC_OFS_CONTROL, 16'h0410);
    rd(TDC_OFS_TIMING, 16'h1304);
    $display("test mid reset done");
    wr(TDC_OFS_CONTROL, 16'h0000);
    base = inits;
    tdc_eng_model_i.fire();
    repeat (3) @(posedge clk_sys);
    check(16'(inits - base), 16'h0001);
    wr(TDC_OFS_CONTROL, 16'h1000);
    base = inits;
    tdc_eng_model_i.fire();
    repeat (3) @(posedge clk_sys);
    check(16'(inits - base), 16'h0000);
    $display("test dc hold done");
    stop_test();
  end
endmodule
`default_nettype wire
